/* File: rtl/accel_mode_control.sv */
`timescale 1ns/100ps
// How it works
// - Key reads 0x45 busy, 0x40 ready, 0x43 keyed
// - Mode change done within three heartbeats
// - Hardware itself rewrites the mode select field
// - Status mode lags request by 2-10 ms
// - Code 000 is sleep, clocks stopped
// - Code 001 is standby, no sampling
// - Code 010 watches; activity jumps to continuous
// - Code 101 samples continuously, watch off
// - Code 110 runs watch and sampling together
// - Code 111 bursts, then returns to sleep; count 0xFF bursts endlessly
// - Bits 4-6 disable X, Y, Z axes
// - Bit 7 fires one-shot burst of count
// - One-shot only from standby; returns to standby
// - External trigger uses pin edges, burst mode
module accel_mode_control #(
  parameter int HEARTBEAT_DIV = accel_mode_pkg::HEARTBEAT_CYCLES,
  parameter int LAG_BEATS = accel_mode_pkg::STATUS_LAG_MIN_MS * 1000
      / accel_mode_pkg::HEARTBEAT_US,
  parameter int STARTUP_DIV = accel_mode_pkg::STARTUP_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  input wire logic activity_detect_i,
  input wire logic sample_done_i,
  input wire logic external_sample_start_enable_i,
  input wire logic external_sample_start_edge_i,
  input wire logic interrupt_out_pin_i,
  output logic [2:0] status_mode_o,
  output logic clocks_run_o,
  output logic sampling_run_o,
  output logic watch_run_o,
  output logic x_channel_enable_o,
  output logic y_channel_enable_o,
  output logic z_channel_enable_o,
  output logic sample_start_o
);
  // ****************************************
  // Parameter check
  // ****************************************
  if (HEARTBEAT_DIV < 1 || HEARTBEAT_DIV > 65536 ||
      STARTUP_DIV < 1 || STARTUP_DIV > 65536 ||
      LAG_BEATS < accel_mode_pkg::TRANSITION_BEATS || LAG_BEATS > 65535) begin
    $error("accel_mode_control: bad timing parameters");
  end
  // ****************************************
  // State
  // ****************************************
  typedef enum {ST_STARTUP, ST_READY, ST_KEYED} init_e;
  typedef struct packed {
    init_e init_state;
    logic [15:0] startup_count;
    logic [15:0] beat_count;
    logic [2:0] mode_select_field;
    logic [2:0] x_y_z_disable;
    logic [7:0] burst_sample_count;
    logic [7:0] burst_done;
    logic [7:0] burst_issued;
    logic burst_oneshot_command;
    logic [2:0] applied_mode;
    logic [1:0] apply_beats;
    logic [15:0] lag_beats;
    logic [2:0] status_mode;
    logic [2:0] pin_sync;
    logic pin_level;
    logic sample_start;
    logic [7:0] rdata;
  } state_s;
  state_s cur, next_cur;
  logic beat, pin_rise, pin_fall, running_mode_change, burst_more;
  wire logic [2:0] channel_enable;

  always_comb begin
    next_cur = cur;
    next_cur.sample_start = 1'b0;
    burst_more = 1'b0;
    beat = cur.beat_count == 16'(HEARTBEAT_DIV - 1);
    next_cur.beat_count = beat ? 16'h0000 : cur.beat_count + 16'h0001;
    // ****************************************
    // Start-up sequence and key
    // ****************************************
    if (cur.init_state == ST_STARTUP) begin
      next_cur.startup_count = cur.startup_count + 16'h0001;
      if (cur.startup_count == 16'(STARTUP_DIV - 1))
        next_cur.init_state = ST_READY;
    end
    if (reg_write_i && reg_addr_i == accel_mode_pkg::INIT_KEY_ADDR &&
        reg_wdata_i == accel_mode_pkg::INIT_KEY_VALUE && cur.init_state == ST_READY)
      next_cur.init_state = ST_KEYED;
    // ****************************************
    // Register reads
    // ****************************************
    if (reg_read_i) begin
      if (reg_addr_i == accel_mode_pkg::INIT_KEY_ADDR) begin
        case (cur.init_state)
          ST_STARTUP: next_cur.rdata = accel_mode_pkg::INIT_READ_BUSY;
          ST_READY: next_cur.rdata = accel_mode_pkg::INIT_READ_DONE;
          default: next_cur.rdata = accel_mode_pkg::INIT_READ_KEYED;
        endcase
      end else begin
        next_cur.rdata = 8'h00;
      end
    end
    // ****************************************
    // External trigger pin
    // ****************************************
    next_cur.pin_sync = {cur.pin_sync[1:0], interrupt_out_pin_i};
    if (cur.pin_sync[2] == cur.pin_sync[1])
      next_cur.pin_level = cur.pin_sync[1];
    pin_rise = next_cur.pin_level && !cur.pin_level;
    pin_fall = !next_cur.pin_level && cur.pin_level;
    // ****************************************
    // Register writes
    // ****************************************
    if (reg_write_i && reg_addr_i == accel_mode_pkg::BURST_COUNT_ADDR)
      next_cur.burst_sample_count = reg_wdata_i;
    if (reg_write_i && reg_addr_i == accel_mode_pkg::MODE_CTRL_ADDR) begin
      next_cur.mode_select_field = reg_wdata_i[accel_mode_pkg::MODE_LSB +: 3];
      next_cur.x_y_z_disable = {reg_wdata_i[accel_mode_pkg::Z_DIS_BIT],
        reg_wdata_i[accel_mode_pkg::Y_DIS_BIT], reg_wdata_i[accel_mode_pkg::X_DIS_BIT]};
      if (reg_wdata_i[accel_mode_pkg::ONESHOT_BIT] && !external_sample_start_enable_i &&
          cur.applied_mode == accel_mode_pkg::MODE_STANDBY) begin
        next_cur.burst_oneshot_command = 1'b1;
        next_cur.mode_select_field = accel_mode_pkg::MODE_BURST;
      end
      next_cur.apply_beats = 2'd0;
    end
    // ****************************************
    // Hardware-driven mode changes
    // ****************************************
    if (cur.applied_mode == accel_mode_pkg::MODE_WATCH && activity_detect_i)
      next_cur.mode_select_field = accel_mode_pkg::MODE_CONT;
    // ****************************************
    // Burst sampling, stops once the count is issued; count 0xFF never stops
    // ****************************************
    if (cur.applied_mode == accel_mode_pkg::MODE_BURST) begin
      burst_more = cur.burst_sample_count == accel_mode_pkg::BURST_ENDLESS ||
        cur.burst_issued == 8'h00 || cur.burst_issued < cur.burst_sample_count;
      if (external_sample_start_enable_i) begin
        if ((external_sample_start_edge_i ? pin_rise : pin_fall) && burst_more)
          next_cur.sample_start = 1'b1;
      end else if (beat && burst_more) begin
        next_cur.sample_start = 1'b1;
      end
      if (next_cur.sample_start && cur.burst_sample_count != accel_mode_pkg::BURST_ENDLESS)
        next_cur.burst_issued = cur.burst_issued + 8'h01;
      if (sample_done_i && cur.burst_sample_count != accel_mode_pkg::BURST_ENDLESS) begin
        next_cur.burst_done = cur.burst_done + 8'h01;
        if (cur.burst_done + 8'h01 >= cur.burst_sample_count) begin
          next_cur.burst_done = 8'h00;
          next_cur.burst_oneshot_command = 1'b0;
          next_cur.mode_select_field = cur.burst_oneshot_command ?
            accel_mode_pkg::MODE_STANDBY : accel_mode_pkg::MODE_SLEEP;
        end
      end
    end
    // ****************************************
    // Heartbeat-timed application and status lag
    // ****************************************
    running_mode_change = cur.applied_mode != cur.mode_select_field;
    if (running_mode_change && beat) begin
      if (cur.apply_beats == 2'(accel_mode_pkg::TRANSITION_BEATS - 1)) begin
        next_cur.applied_mode = cur.mode_select_field;
        next_cur.apply_beats = 2'd0;
        next_cur.lag_beats = 16'h0000;
        if (cur.applied_mode != accel_mode_pkg::MODE_BURST) begin
          next_cur.burst_done = 8'h00;
          next_cur.burst_issued = 8'h00;
        end
      end else begin
        next_cur.apply_beats = cur.apply_beats + 2'd1;
      end
    end
    if (cur.status_mode != cur.applied_mode && beat) begin
      next_cur.lag_beats = cur.lag_beats + 16'h0001;
      if (cur.lag_beats >= 16'(LAG_BEATS - accel_mode_pkg::TRANSITION_BEATS))
        next_cur.status_mode = cur.applied_mode;
    end
    if (!reset_n_i) begin
      next_cur = '0;
      next_cur.init_state = ST_STARTUP;
      next_cur.mode_select_field = accel_mode_pkg::MODE_CTRL_RESET[2:0];
      next_cur.burst_sample_count = accel_mode_pkg::BURST_COUNT_RESET;
      next_cur.pin_sync = 3'b111;
      next_cur.pin_level = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    cur <= next_cur;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata_o = cur.rdata;
  assign status_mode_o = cur.status_mode;
  assign clocks_run_o = cur.applied_mode != accel_mode_pkg::MODE_SLEEP;
  assign sampling_run_o = cur.applied_mode == accel_mode_pkg::MODE_CONT ||
    cur.applied_mode == accel_mode_pkg::MODE_COMBINED ||
    cur.applied_mode == accel_mode_pkg::MODE_BURST;
  assign watch_run_o = cur.applied_mode == accel_mode_pkg::MODE_WATCH ||
    cur.applied_mode == accel_mode_pkg::MODE_COMBINED;
  // ****************************************
  // Per-axis enables
  // ****************************************
  for (genvar ch = 0; ch < 3; ch++) begin
    assign channel_enable[ch] = !cur.x_y_z_disable[ch];
  end
  assign x_channel_enable_o = channel_enable[0];
  assign y_channel_enable_o = channel_enable[1];
  assign z_channel_enable_o = channel_enable[2];
  assign sample_start_o = cur.sample_start;
endmodule

/* File: rtl/accel_mode_pkg.sv */
package accel_mode_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] INIT_KEY_ADDR = 8'h0F;
  localparam logic [7:0] MODE_CTRL_ADDR = 8'h10;
  localparam logic [7:0] BURST_COUNT_ADDR = 8'h29;
  localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
  localparam logic [7:0] BURST_COUNT_RESET = 8'h00;
  // ****************************************
  // Start-up key values
  // ****************************************
  localparam logic [7:0] INIT_KEY_VALUE = 8'h42;
  localparam logic [7:0] INIT_READ_BUSY = 8'h45;
  localparam logic [7:0] INIT_READ_DONE = 8'h40;
  localparam logic [7:0] INIT_READ_KEYED = 8'h43;
  // ****************************************
  // Fields of the mode control register
  // ****************************************
  localparam int MODE_LSB = 0;
  localparam int X_DIS_BIT = 4;
  localparam int Y_DIS_BIT = 5;
  localparam int Z_DIS_BIT = 6;
  localparam int ONESHOT_BIT = 7;
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_WATCH = 3'h2;
  localparam logic [2:0] MODE_CONT = 3'h5;
  localparam logic [2:0] MODE_COMBINED = 3'h6;
  localparam logic [2:0] MODE_BURST = 3'h7;
  localparam logic [7:0] BURST_ENDLESS = 8'hFF;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int HEARTBEAT_US = 100;
  localparam int HEARTBEAT_CYCLES = HEARTBEAT_US * (CLK_HZ / 1_000_000);
  localparam int TRANSITION_BEATS = 3;
  localparam int STATUS_LAG_MIN_MS = 2;
  localparam int STARTUP_US = 50;
  localparam int STARTUP_CYCLES = STARTUP_US * (CLK_HZ / 1_000_000);
endpackage

/* File: verif/accel_mode_properties.sv */
`timescale 1ns/100ps
module accel_mode_properties #(
  parameter int HEARTBEAT_DIV = 2,
  parameter int LAG_BEATS = 4
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [2:0] status_mode_o,
  input wire logic clocks_run_o,
  input wire logic sampling_run_o,
  input wire logic x_channel_enable_o,
  input wire logic y_channel_enable_o,
  input wire logic z_channel_enable_o,
  input wire logic sample_start_o
);
  localparam int REACH = (LAG_BEATS + 3) * HEARTBEAT_DIV * 2;
  logic [2:0] want;
  logic mw;
  assign mw = reg_write_i && reg_addr_i == 8'h10 && !reg_wdata_i[7] &&
      reg_wdata_i[2:0] inside {3'h0, 3'h1, 3'h5, 3'h6};
  always_ff @(posedge clk_i) begin
    if (mw) begin
      want <= reg_wdata_i[2:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_reset_status: assert property ($rose(reset_n_i) |-> status_mode_o == 3'h0)
    else $error("status not cleared");
  a_reset_axes: assert property ($rose(reset_n_i) |->
    x_channel_enable_o && y_channel_enable_o && z_channel_enable_o) else $error("axes off");
  a_sleep_no_sample: assert property (!clocks_run_o |-> !sampling_run_o)
    else $error("sampling without clocks");
  a_start_one_cycle: assert property (sample_start_o |=> !sample_start_o)
    else $error("start pulse too long");
  a_key_readback: assert property (reg_read_i && reg_addr_i == 8'h0F |->
    ##2 reg_rdata_o inside {8'h45, 8'h40, 8'h43}) else $error("bad key readback");
  a_mode_read_zero: assert property (reg_read_i && reg_addr_i == 8'h10 |-> ##2
    reg_rdata_o == 8'h00) else $error("mode register readable");
  a_status_legal: assert property (!(status_mode_o inside {3'h3, 3'h4}))
    else $error("reserved mode reported");
  a_mode_reach: assert property (mw |=> ##[0:REACH] status_mode_o == want)
    else $error("mode not reached");
  a_mode_lag: assert property (mw && status_mode_o != reg_wdata_i[2:0] |=>
    (status_mode_o != want) [*3]) else $error("status followed too fast");
  cover property (mw);
  cover property (sample_start_o);
  cover property (status_mode_o == 3'h5);
endmodule

/* File: verif/accel_sensor_model.sv */
`timescale 1ns/100ps
module accel_sensor_model (
  input wire logic clk_i,
  input wire logic sample_start_i,
  output logic sample_done_o = 1'b0
);
  // Each sample request is answered by one done pulse a cycle later
  always_ff @(posedge clk_i) begin
    sample_done_o <= sample_start_i;
  end
endmodule

/* File: verif/test_accel_mode_control.sv */
`timescale 1ns/100ps
module test_accel_mode_control;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_write_i = 1'b0;
  logic reg_read_i = 1'b0;
  logic activity_detect_i = 1'b0;
  logic external_sample_start_enable_i = 1'b0;
  logic external_sample_start_edge_i = 1'b0;
  logic interrupt_out_pin_i = 1'b1;
  logic sample_done_i;
  logic [7:0] reg_rdata_o;
  logic [2:0] status_mode_o;
  logic clocks_run_o, sampling_run_o, watch_run_o, sample_start_o;
  logic x_channel_enable_o, y_channel_enable_o, z_channel_enable_o;
  logic [2:0] modes [4] = '{3'h1, 3'h5, 3'h6, 3'h0};
  logic [7:0] runs [4] = '{8'h04, 8'h06, 8'h07, 8'h00};
  int error_cnt = 0;
  int cmp_count = 0;
  int pulses = 0;
  accel_mode_control #(.HEARTBEAT_DIV(2), .LAG_BEATS(4), .STARTUP_DIV(8)) i_accel_mode_control (
    .clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o,
    .activity_detect_i, .sample_done_i, .external_sample_start_enable_i,
    .external_sample_start_edge_i, .interrupt_out_pin_i, .status_mode_o,
    .clocks_run_o, .sampling_run_o, .watch_run_o, .x_channel_enable_o, .y_channel_enable_o,
    .z_channel_enable_o, .sample_start_o);
  accel_sensor_model i_accel_sensor_model (
    .clk_i, .sample_start_i(sample_start_o), .sample_done_o(sample_done_i));
  initial forever #50 clk_i = ~clk_i;
  always @(posedge clk_i) if (sample_start_o === 1'b1) pulses++;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_write_i = 1'b1;
    @(negedge clk_i);
    reg_write_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_read_i = 1'b1;
    @(negedge clk_i);
    reg_read_i = 1'b0;
    @(negedge clk_i);
    chk(reg_rdata_o, exp);
  endtask
  task automatic wait_mode(input logic [2:0] m);
    for (int n = 0; n < 100 && status_mode_o !== m; n++) begin
      @(negedge clk_i);
    end
    chk({5'h00, status_mode_o}, {5'h00, m});
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (16) @(negedge clk_i);
    reset_n_i = 1'b1;
    rd(8'h0F, 8'h45);
    chk({4'h0, status_mode_o, clocks_run_o}, 8'h00);
    chk({5'h00, x_channel_enable_o, y_channel_enable_o, z_channel_enable_o}, 8'h07);
    rd(8'h10, 8'h00);
    repeat (10) @(negedge clk_i);
    rd(8'h0F, 8'h40);
    wr(8'h0F, 8'h42);
    rd(8'h0F, 8'h43);
    $display("test startup done");
    foreach (modes[i]) begin
      wr(8'h10, {5'h00, modes[i]});
      wait_mode(modes[i]);
      chk({5'h00, clocks_run_o, sampling_run_o, watch_run_o}, runs[i]);
    end
    $display("test modes done");
    wr(8'h10, 8'h71);
    wait_mode(3'h1);
    chk({5'h00, x_channel_enable_o, y_channel_enable_o, z_channel_enable_o}, 8'h00);
    wr(8'h10, 8'h21);
    repeat (12) @(negedge clk_i);
    chk({5'h00, x_channel_enable_o, y_channel_enable_o, z_channel_enable_o}, 8'h05);
    wr(8'h10, 8'h02);
    wait_mode(3'h2);
    chk({6'h00, sampling_run_o, watch_run_o}, 8'h01);
    activity_detect_i = 1'b1;
    wait_mode(3'h5);
    activity_detect_i = 1'b0;
    $display("test axes and watch done");
    wr(8'h29, 8'h03);
    wr(8'h10, 8'h01);
    wait_mode(3'h1);
    pulses = 0;
    wr(8'h10, 8'h81);
    repeat (60) @(negedge clk_i);
    chk(pulses[7:0], 8'h03);
    wait_mode(3'h1);
    wr(8'h29, 8'h02);
    pulses = 0;
    wr(8'h10, 8'h07);
    repeat (60) @(negedge clk_i);
    chk(pulses[7:0], 8'h02);
    wait_mode(3'h0);
    $display("test bursts done");
    external_sample_start_enable_i = 1'b1;
    external_sample_start_edge_i = 1'b1;
    wr(8'h10, 8'h07);
    wait_mode(3'h7);
    pulses = 0;
    interrupt_out_pin_i = 1'b0;
    repeat (6) @(negedge clk_i);
    chk(pulses[7:0], 8'h00);
    interrupt_out_pin_i = 1'b1;
    repeat (6) @(negedge clk_i);
    chk(pulses[7:0], 8'h01);
    interrupt_out_pin_i = 1'b0;
    repeat (6) @(negedge clk_i);
    interrupt_out_pin_i = 1'b1;
    repeat (6) @(negedge clk_i);
    chk(pulses[7:0], 8'h02);
    wait_mode(3'h0);
    $display("test pin trigger done");
    wr(8'h10, 8'h75);
    wait_mode(3'h5);
    chk({5'h00, x_channel_enable_o, y_channel_enable_o, z_channel_enable_o}, 8'h00);
    reset_n_i = 1'b0;
    repeat (4) @(negedge clk_i);
    reset_n_i = 1'b1;
    chk({4'h0, status_mode_o, clocks_run_o}, 8'h00);
    chk({5'h00, x_channel_enable_o, y_channel_enable_o, z_channel_enable_o}, 8'h07);
    rd(8'h0F, 8'h45);
    $display("test reset done");
    end_sim();
  end
endmodule
bind accel_mode_control accel_mode_properties #(
  .HEARTBEAT_DIV(HEARTBEAT_DIV), .LAG_BEATS(LAG_BEATS)) i_accel_mode_properties (
  .clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o,
  .status_mode_o, .clocks_run_o, .sampling_run_o, .x_channel_enable_o, .y_channel_enable_o,
  .z_channel_enable_o, .sample_start_o);
